// ---- rtl/idw_pkg.sv ----
package idw_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_INSTR = 8'h00;
  localparam logic [7:0] A_OPERAND = 8'h04;
  localparam logic [7:0] A_ACC = 8'h08;
  localparam logic [7:0] A_PCLATCH = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_DECODE = 8'h14;
  localparam logic [7:0] A_RESULT = 8'h18;
  localparam logic [7:0] A_PC = 8'h1C;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [13:0] INSTR_RST = 14'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [4:0] PCLATCH_RST = 5'h00;
  localparam logic [12:0] PC_RST = 13'h0000;

  // ----------------------------------------------------------------
  // File addresses and status bits
  // ----------------------------------------------------------------
  localparam logic [6:0] F_PC_LOW = 7'h02;
  localparam logic [6:0] F_STATUS = 7'h03;
  localparam int C_BIT = 0;
  localparam int HALF_BIT = 1;
  localparam int Z_BIT = 2;

  // ----------------------------------------------------------------
  // Instruction word fields
  // ----------------------------------------------------------------
  localparam int FREG_LSB = 0;
  localparam int DEST_POS = 7;
  localparam int BITPOS_LSB = 7;
  localparam int FUNC_LSB = 8;
  localparam int CLASS_LSB = 12;

  // ----------------------------------------------------------------
  // Read-only register layouts
  // ----------------------------------------------------------------
  localparam int DEC_BIT_LSB = 8;
  localparam int DEC_DEST = 11;
  localparam int DEC_CLS_LSB = 12;
  localparam int DEC_LIT_LSB = 16;
  localparam int RES_FWR = 8;
  localparam int RES_SKIP = 9;
  localparam int RES_PCCHG = 10;
  localparam int RES_TWO = 11;
  localparam int RES_BUSY = 12;
  localparam int RES_SLEEP = 13;
  localparam int RES_WDT = 14;

  // ----------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------
  localparam int OSC_PER_CYCLE = 4;
  localparam int STACK_DEPTH = 8;

  typedef enum logic [1:0] {
    CLS_BYTE = 2'h0,
    CLS_BIT = 2'h1,
    CLS_LITCTL = 2'h2
  } idw_class_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_EXEC = 3'b010,
    SEQ_NOP = 3'b100
  } idw_seq_t;

endpackage : idw_pkg

// ---- rtl/idw_dec_if.sv ----
interface idw_dec_if;
  logic [13:0] word;
  idw_pkg::idw_class_t cls;
  logic [3:0] func;
  logic dest;
  logic [6:0] freg;
  logic [2:0] bitpos;
  logic [10:0] lit11;
  logic is_call;
  logic is_goto;
  logic is_ret;
  logic is_retlw;
  logic is_retfie;
  logic is_sleep;
  logic is_wdt;
  logic is_movwf;

  modport dec (input word, output cls, func, dest, freg, bitpos, lit11, is_call, is_goto,
    is_ret, is_retlw, is_retfie, is_sleep, is_wdt, is_movwf);
  modport core (output word, input cls, func, dest, freg, bitpos, lit11, is_call, is_goto,
    is_ret, is_retlw, is_retfie, is_sleep, is_wdt, is_movwf);
endinterface : idw_dec_if

// ---- rtl/idw_decode.sv ----
module idw_decode (
  idw_dec_if.dec bus // Word in, fields out
);
  wire [5:0] hi6 = bus.word[13:8];
  wire ctl_group = (hi6 == 6'h00) && !bus.word[7];

  // ----------------------------------------------------------------
  // Field split
  // ----------------------------------------------------------------
  assign bus.cls = bus.word[13] ? idw_pkg::CLS_LITCTL : // RQ2
    (bus.word[12] ? idw_pkg::CLS_BIT : idw_pkg::CLS_BYTE);
  assign bus.func = bus.word[idw_pkg::FUNC_LSB +: 4]; // RQ1
  assign bus.dest = bus.word[idw_pkg::DEST_POS]; // RQ3
  assign bus.freg = bus.word[idw_pkg::FREG_LSB +: 7]; // RQ4
  assign bus.bitpos = bus.word[idw_pkg::BITPOS_LSB +: 3]; // RQ5
  assign bus.lit11 = bus.word[10:0]; // RQ6

  // ----------------------------------------------------------------
  // Control forms; don't-care bits never enter a compare
  // ----------------------------------------------------------------
  assign bus.is_call = bus.word[13:11] == 3'h4;
  assign bus.is_goto = bus.word[13:11] == 3'h5;
  assign bus.is_retlw = bus.word[13:10] == 4'hD; // RQ7
  assign bus.is_ret = ctl_group && (bus.word[6:0] == 7'h08);
  assign bus.is_retfie = ctl_group && (bus.word[6:0] == 7'h09);
  assign bus.is_sleep = ctl_group && (bus.word[6:0] == 7'h63);
  assign bus.is_wdt = ctl_group && (bus.word[6:0] == 7'h64);
  assign bus.is_movwf = (hi6 == 6'h00) && bus.word[7];
endmodule : idw_decode

// ---- rtl/idw_seq.sv ----
module idw_seq #(
  parameter int Q_PER = idw_pkg::OSC_PER_CYCLE
) (
  input wire logic mclk, // Core clock
  input wire logic arst_n, // Async reset
  input wire logic start, // Begin an instruction
  input wire logic two_cycle, // Sampled at commit
  output logic busy, // Instruction in flight
  output logic commit, // Last clock of first cycle
  output logic [1:0] q_phase // Oscillator period within cycle
);
  idw_pkg::idw_seq_t state_reg, state_next;
  logic [1:0] q_reg;
  wire q_last = q_reg == 2'(Q_PER - 1);

  assign busy = state_reg != idw_pkg::SEQ_IDLE;
  assign commit = (state_reg == idw_pkg::SEQ_EXEC) && q_last; // RQ8
  assign q_phase = q_reg;

  always_comb begin
    case (state_reg)
      idw_pkg::SEQ_IDLE: state_next = start ? idw_pkg::SEQ_EXEC : idw_pkg::SEQ_IDLE;
      idw_pkg::SEQ_EXEC: begin
        if (!q_last) state_next = idw_pkg::SEQ_EXEC;
        else if (two_cycle) state_next = idw_pkg::SEQ_NOP; // RQ9
        else state_next = idw_pkg::SEQ_IDLE;
      end
      idw_pkg::SEQ_NOP: state_next = q_last ? idw_pkg::SEQ_IDLE : idw_pkg::SEQ_NOP;
      default: state_next = idw_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= idw_pkg::SEQ_IDLE;
      q_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      q_reg <= (!busy || q_last) ? 2'h0 : q_reg + 2'h1; // RQ10
    end
  end
endmodule : idw_seq

// ---- rtl/idw_core.sv ----
// Operation
// (RQ1) Each instruction is one 14-bit word: opcode plus operand fields.
// (RQ2) Words are sorted into byte, bit, and literal-and-control classes.
// (RQ3) Byte ops: target bit 0 sends result to accumulator, 1 to file.
// (RQ4) Register number is a 7-bit field addressing files 0x00 to 0x7F.
// (RQ5) Bit ops: a 3-bit field picks one of eight bits.
// (RQ6) Literals are eight bits for data, eleven bits for jump targets.
// (RQ7) Don't-care opcode bits are ignored; tools should write them as zero.
// (RQ8) Instructions take one cycle unless a test succeeds or PC changes.
// (RQ9) Successful tests and PC changes take two cycles, second one idle.
// (RQ10) One instruction cycle is exactly four core clock periods.
// (RQ11) Writing PC low byte loads upper bits from the high latch.
// (RQ12) Flags made by an instruction override those bits when status is written.
// (RQ13) Bit set and clear read the whole byte, modify, write it back.
module idw_core (
  input wire logic mclk, // Core clock
  input wire logic arst_n, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  output logic [1:0] q_phase, // Period within instruction cycle
  output logic instr_busy, // Instruction in flight
  output logic file_wr, // One-clock file write strobe
  output logic [6:0] file_addr, // File write address
  output logic [7:0] file_data // File write data
);
  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic dp_valid_reg, dp_write_reg, dp_map_reg;
  logic [7:0] dp_addr_reg;
  logic [31:0] rd_word, hrdata_reg;
  logic busy, commit, two_now;

  wire addr_take = hsel && htrans[1] && hready;
  wire addr_map = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'h0);
  // Writes wait out a running instruction, so no write meets a commit
  wire stall = dp_valid_reg && dp_write_reg && busy;
  wire wr_en = dp_valid_reg && dp_write_reg && dp_map_reg && !stall;
  wire wr_instr = wr_en && (dp_addr_reg == idw_pkg::A_INSTR);
  wire wr_operand = wr_en && (dp_addr_reg == idw_pkg::A_OPERAND);
  wire wr_acc = wr_en && (dp_addr_reg == idw_pkg::A_ACC);
  wire wr_pclatch = wr_en && (dp_addr_reg == idw_pkg::A_PCLATCH);
  wire wr_status = wr_en && (dp_addr_reg == idw_pkg::A_STATUS);

  assign hreadyout = !stall;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_map_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
    end else if (hready) begin
      dp_valid_reg <= addr_take;
      dp_write_reg <= hwrite;
      dp_map_reg <= addr_map;
      dp_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) hrdata_reg <= 32'h0000_0000;
    else if (addr_take && !hwrite) hrdata_reg <= addr_map ? rd_word : 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Decode and timing
  // ----------------------------------------------------------------
  idw_dec_if dif ();
  logic [13:0] instr_reg;

  assign dif.word = instr_reg;

  idw_decode u_dec (
    .bus (dif.dec)
  );

  idw_seq #(
    .Q_PER (idw_pkg::OSC_PER_CYCLE)
  ) u_seq (
    .mclk (mclk),
    .arst_n (arst_n),
    .start (wr_instr),
    .two_cycle (two_now),
    .busy (busy),
    .commit (commit),
    .q_phase (q_phase)
  );

  assign instr_busy = busy;

  // ----------------------------------------------------------------
  // Architectural state
  // ----------------------------------------------------------------
  logic [7:0] operand_reg, acc_reg, status_reg, res_reg;
  logic [4:0] pclatch_reg;
  logic [12:0] pc_reg;
  logic [12:0] stack_mem [idw_pkg::STACK_DEPTH];
  logic [2:0] sp_reg;
  logic fwr_reg, skip_reg, pcchg_reg, two_reg, sleep_reg, wdt_reg;

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
      input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {h[4], s[8], s[7:0]};
  endfunction : add8

  // Low byte of the PC reads back as the executing instruction's address
  wire [7:0] fval = (dif.freg == idw_pkg::F_STATUS) ? status_reg :
    (dif.freg == idw_pkg::F_PC_LOW) ? pc_reg[7:0] : operand_reg;
  wire [7:0] lit8 = dif.lit11[7:0];
  wire [7:0] bmask = 8'h01 << dif.bitpos;
  logic [7:0] r;
  logic [9:0] t;
  logic cy, dcy, zm, cm, dcm, to_w, to_f, skip, arith;

  always_comb begin
    t = 10'h000;
    r = 8'h00;
    cy = status_reg[idw_pkg::C_BIT];
    dcy = status_reg[idw_pkg::HALF_BIT];
    zm = 1'b0;
    cm = 1'b0;
    dcm = 1'b0;
    to_w = 1'b0;
    to_f = 1'b0;
    skip = 1'b0;
    arith = 1'b0;
    case (dif.cls)
      idw_pkg::CLS_BYTE: begin
        to_w = !dif.dest; // RQ3
        to_f = dif.dest; // RQ3
        zm = (dif.func != 4'h0) && (dif.func < 4'hB);
        case (dif.func)
          4'h0: begin
            r = acc_reg;
            to_w = 1'b0;
            to_f = dif.is_movwf;
          end
          4'h1: r = 8'h00;
          4'h2: t = add8(fval, ~acc_reg, 1'b1);
          4'h3: r = fval - 8'h01;
          4'h4: r = fval | acc_reg;
          4'h5: r = fval & acc_reg;
          4'h6: r = fval ^ acc_reg;
          4'h7: t = add8(fval, acc_reg, 1'b0);
          4'h8: r = fval;
          4'h9: r = ~fval;
          4'hA: r = fval + 8'h01;
          4'hB: begin
            r = fval - 8'h01;
            skip = r == 8'h00; // RQ9
          end
          4'hC: begin
            r = {cy, fval[7:1]};
            cy = fval[0];
            cm = 1'b1;
          end
          4'hD: begin
            r = {fval[6:0], cy};
            cy = fval[7];
            cm = 1'b1;
          end
          4'hE: r = {fval[3:0], fval[7:4]};
          4'hF: begin
            r = fval + 8'h01;
            skip = r == 8'h00; // RQ9
          end
          default: r = 8'h00;
        endcase
        arith = (dif.func == 4'h2) || (dif.func == 4'h7);
      end
      idw_pkg::CLS_BIT: begin
        to_f = !dif.func[3]; // RQ13
        case (dif.func[3:2])
          2'h0: r = fval & ~bmask; // RQ13
          2'h1: r = fval | bmask; // RQ13
          2'h2: skip = !fval[dif.bitpos]; // RQ5
          2'h3: skip = fval[dif.bitpos]; // RQ5
          default: skip = 1'b0;
        endcase
      end
      default: begin
        if (dif.word[12]) begin
          to_w = 1'b1;
          zm = dif.func[3];
          casez (dif.func)
            4'b0???: r = lit8; // RQ6
            4'b1000: r = lit8 | acc_reg;
            4'b1001: r = lit8 & acc_reg;
            4'b1010: r = lit8 ^ acc_reg;
            4'b110?: t = add8(lit8, ~acc_reg, 1'b1); // RQ7
            4'b111?: t = add8(lit8, acc_reg, 1'b0); // RQ7
            default: begin
              to_w = 1'b0;
              zm = 1'b0;
            end
          endcase
          arith = dif.func[3:2] == 2'h3;
        end
      end
    endcase
    if (arith) begin
      r = t[7:0];
      cy = t[8];
      dcy = t[9];
      cm = 1'b1;
      dcm = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Program counter, stack and status
  // ----------------------------------------------------------------
  wire pc_low_wr = to_f && (dif.freg == idw_pkg::F_PC_LOW);
  wire st_wr = to_f && (dif.freg == idw_pkg::F_STATUS);
  wire ext_wr = to_f && !pc_low_wr && !st_wr;
  wire pc_jump = dif.is_call || dif.is_goto;
  wire pc_pop = dif.is_ret || dif.is_retlw || dif.is_retfie;
  wire pc_chg = pc_jump || pc_pop || pc_low_wr;
  wire [12:0] pc_inc = pc_reg + 13'h0001;
  wire [12:0] pc_top = stack_mem[sp_reg - 3'h1];
  logic [12:0] pc_next;
  logic [7:0] st_next;

  assign two_now = skip || pc_chg; // RQ8

  always_comb begin
    if (pc_low_wr) pc_next = {pclatch_reg, r}; // RQ11
    else if (pc_jump) pc_next = {pclatch_reg[4:3], dif.lit11}; // RQ6
    else if (pc_pop) pc_next = pc_top;
    else if (skip) pc_next = pc_reg + 13'h0002;
    else pc_next = pc_inc;
  end

  always_comb begin
    st_next = st_wr ? r : status_reg;
    if (zm) st_next[idw_pkg::Z_BIT] = r == 8'h00; // RQ12
    if (cm) st_next[idw_pkg::C_BIT] = cy; // RQ12
    if (dcm) st_next[idw_pkg::HALF_BIT] = dcy; // RQ12
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) instr_reg <= idw_pkg::INSTR_RST;
    else if (wr_instr) instr_reg <= hwdata[13:0]; // RQ1
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) acc_reg <= idw_pkg::BYTE_RST;
    else if (wr_acc) acc_reg <= hwdata[7:0];
    else if (commit && to_w) acc_reg <= r; // RQ3
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) operand_reg <= idw_pkg::BYTE_RST;
    else if (wr_operand) operand_reg <= hwdata[7:0];
    else if (commit && ext_wr) operand_reg <= r; // RQ13
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) status_reg <= idw_pkg::BYTE_RST;
    else if (wr_status) status_reg <= hwdata[7:0];
    else if (commit) status_reg <= st_next; // RQ12
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) pclatch_reg <= idw_pkg::PCLATCH_RST;
    else if (wr_pclatch) pclatch_reg <= hwdata[4:0];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg <= idw_pkg::PC_RST;
      sp_reg <= 3'h0;
    end else if (commit) begin
      pc_reg <= pc_next; // RQ11
      if (dif.is_call) sp_reg <= sp_reg + 3'h1;
      else if (pc_pop) sp_reg <= sp_reg - 3'h1;
    end
  end

  // Circular stack without overflow detection, so no reset is needed
  always_ff @(posedge mclk) begin
    if (commit && dif.is_call) stack_mem[sp_reg] <= pc_inc;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      res_reg <= 8'h00;
      fwr_reg <= 1'b0;
      skip_reg <= 1'b0;
      pcchg_reg <= 1'b0;
      two_reg <= 1'b0;
      sleep_reg <= 1'b0;
      wdt_reg <= 1'b0;
      file_wr <= 1'b0;
      file_addr <= 7'h00;
      file_data <= 8'h00;
    end else begin
      file_wr <= commit && ext_wr; // RQ3
      if (commit) begin
        res_reg <= r;
        fwr_reg <= to_f;
        skip_reg <= skip;
        pcchg_reg <= pc_chg;
        two_reg <= two_now; // RQ9
        sleep_reg <= dif.is_sleep;
        wdt_reg <= dif.is_wdt;
        file_addr <= dif.freg; // RQ4
        file_data <= r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      idw_pkg::A_INSTR: rd_word[13:0] = instr_reg;
      idw_pkg::A_OPERAND: rd_word[7:0] = operand_reg;
      idw_pkg::A_ACC: rd_word[7:0] = acc_reg;
      idw_pkg::A_PCLATCH: rd_word[4:0] = pclatch_reg;
      idw_pkg::A_STATUS: rd_word[7:0] = status_reg;
      idw_pkg::A_DECODE: begin
        rd_word[6:0] = dif.freg;
        rd_word[idw_pkg::DEC_BIT_LSB +: 3] = dif.bitpos;
        rd_word[idw_pkg::DEC_DEST] = dif.dest;
        rd_word[idw_pkg::DEC_CLS_LSB +: 2] = dif.cls; // RQ2
        rd_word[idw_pkg::DEC_LIT_LSB +: 11] = dif.lit11;
      end
      idw_pkg::A_RESULT: begin
        rd_word[7:0] = res_reg;
        rd_word[idw_pkg::RES_FWR] = fwr_reg;
        rd_word[idw_pkg::RES_SKIP] = skip_reg;
        rd_word[idw_pkg::RES_PCCHG] = pcchg_reg;
        rd_word[idw_pkg::RES_TWO] = two_reg;
        rd_word[idw_pkg::RES_BUSY] = busy;
        rd_word[idw_pkg::RES_SLEEP] = sleep_reg;
        rd_word[idw_pkg::RES_WDT] = wdt_reg;
      end
      idw_pkg::A_PC: rd_word[12:0] = pc_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end
endmodule : idw_core

// ---- bench/idw_core_assertions.sv ----
module idw_core_assertions (
  input wire logic mclk, // Core clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [1:0] q_phase, // Period in cycle
  input wire logic instr_busy, // Instruction running
  input wire logic file_wr // File write strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] busy_cnt_reg;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // Counts clocks of one instruction, so length limits need no long repetition
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) busy_cnt_reg <= 4'h0;
    else if (instr_busy) busy_cnt_reg <= busy_cnt_reg + 4'h1;
    else busy_cnt_reg <= 4'h0;
  end
  phase_idle_a: assert property (!instr_busy |-> q_phase == 2'h0)
    else $error("phase not zero while idle");
  phase_step_a: assert property (instr_busy && $past(instr_busy)
    |-> q_phase == $past(q_phase) + 2'h1)
    else $error("phase did not advance by one");
  phase_start_a: assert property ($rose(instr_busy) |-> q_phase == 2'h0)
    else $error("instruction did not start at phase zero");
  min_cycle_a: assert property ($rose(instr_busy) |-> instr_busy [*4])
    else $error("instruction shorter than four periods");
  busy_len_a: assert property ($fell(instr_busy)
    |-> busy_cnt_reg == 4'h4 || busy_cnt_reg == 4'h8)
    else $error("instruction length not four or eight periods");
  busy_cap_a: assert property (instr_busy |-> busy_cnt_reg < 4'h8)
    else $error("instruction longer than two cycles");
  commit_wr_a: assert property (file_wr |-> $past(instr_busy) && $past(q_phase) == 2'h3)
    else $error("file write not after last period");
  wr_pulse_a: assert property (file_wr |=> !file_wr)
    else $error("file write strobe longer than one clock");
endmodule : idw_core_assertions

// ---- bench/idw_file_model.sv ----
module idw_file_model (
  input wire logic mclk, // Core clock
  input wire logic file_wr, // Write strobe
  input wire logic [6:0] file_addr, // File number
  input wire logic [7:0] file_data // Result byte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:127];
  // Whole byte stored, as a read-modify-write leaves it
  always_ff @(posedge mclk) begin
    if (file_wr) mem[file_addr] <= file_data;
  end
endmodule : idw_file_model

// ---- bench/idw_core_tb.sv ----
module idw_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, arst_n, hsel, hwrite, hready, hreadyout, hresp, instr_busy, file_wr;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans, q_phase;
  logic [2:0] hsize;
  logic [6:0] file_addr;
  logic [7:0] file_data;
  int n_errors, samples_checked, cyc;
  assign hready = hreadyout;
  idw_core dut (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .q_phase(q_phase), .instr_busy(instr_busy),
    .file_wr(file_wr), .file_addr(file_addr), .file_data(file_data));
  idw_file_model fmem (.mclk(mclk), .file_wr(file_wr), .file_addr(file_addr),
    .file_data(file_data));
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task results;
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(rdv, exp);
    chk({31'h0, hresp}, 32'h00000000);
  endtask : rd
  // Write one word, count the clocks it keeps the core busy
  task run(input logic [13:0] w, input int ncyc);
    wr(idw_pkg::A_INSTR, {18'h0, w});
    cyc = 0;
    @(posedge mclk);
    while (instr_busy === 1'b1 && cyc < 20) begin
      cyc++;
      @(posedge mclk);
    end
    @(posedge mclk);
    chk(32'(cyc), 32'(ncyc));
  endtask : run
  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (6000) @(posedge mclk);
    n_errors++;
    results();
  end
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    arst_n = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    rd(8'h20, 32'h00000000);
    run(14'h305A, 4);
    rd(idw_pkg::A_ACC, 32'h0000005A);
    xfer(1'b0, idw_pkg::A_DECODE, 32'h00000000);
    chk(rdv & 32'h07FF3000, 32'h005A2000);
    // Don't-care positions set must decode the same
    run(14'h33A5, 4);
    rd(idw_pkg::A_ACC, 32'h000000A5);
    wr(idw_pkg::A_ACC, 32'h0000005A);
    wr(idw_pkg::A_OPERAND, 32'h00000027);
    run(14'h077F, 4);
    rd(idw_pkg::A_ACC, 32'h00000081);
    run(14'h07FF, 4);
    rd(idw_pkg::A_ACC, 32'h00000081);
    chk({24'h000000, fmem.mem[7'h7F]}, 32'h000000A8);
    xfer(1'b0, idw_pkg::A_DECODE, 32'h00000000);
    chk(rdv & 32'h0000387F, 32'h0000087F);
    for (int b = 0; b < 8; b++) begin
      wr(idw_pkg::A_OPERAND, 32'h00000000);
      run(14'h1420 | 14'(b << 7), 4);
      chk({24'h000000, fmem.mem[7'h20]}, 32'h00000001 << b);
    end
    wr(idw_pkg::A_OPERAND, 32'h000000FF);
    run(14'h11A0, 4);
    chk({24'h000000, fmem.mem[7'h20]}, 32'h000000F7);
    // Bit 0 of file 0x20 is now set: set-test skips, clear-test does not
    run(14'h1C20, 8);
    xfer(1'b0, idw_pkg::A_RESULT, 32'h00000000);
    chk(rdv & 32'h00000A00, 32'h00000A00);
    run(14'h1820, 4);
    wr(idw_pkg::A_PCLATCH, 32'h00000018);
    run(14'h2FFF, 8);
    rd(idw_pkg::A_PC, 32'h00001FFF);
    wr(idw_pkg::A_PCLATCH, 32'h00000005);
    wr(idw_pkg::A_ACC, 32'h00000034);
    run(14'h0082, 8);
    rd(idw_pkg::A_PC, 32'h00000534);
    wr(idw_pkg::A_STATUS, 32'h000000FF);
    run(14'h0183, 4);
    rd(idw_pkg::A_STATUS, 32'h00000004);
    // Call pushes the next address, return brings it back
    run(14'h2010, 8);
    rd(idw_pkg::A_PC, 32'h00000010);
    run(14'h0008, 8);
    rd(idw_pkg::A_PC, 32'h00000536);
    // Literal minus accumulator borrows: carry clear, half flag set
    run(14'h3C05, 4);
    rd(idw_pkg::A_ACC, 32'h000000D1);
    rd(idw_pkg::A_STATUS, 32'h00000002);
    // A write issued mid-instruction is held off, not lost
    wr(idw_pkg::A_INSTR, 32'h00003011);
    wr(idw_pkg::A_ACC, 32'h00000022);
    rd(idw_pkg::A_ACC, 32'h00000022);
    results();
  end
endmodule : idw_core_tb
bind idw_core idw_core_assertions u_chk (.mclk(mclk), .arst_n(arst_n), .q_phase(q_phase),
  .instr_busy(instr_busy), .file_wr(file_wr));
